//--- hdl/iqe_receiver.sv
// Receiver end: differential sense, sync, Gray decode, counting
`default_nettype none
module iqe_receiver
    import iqe_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire iqe_mul_t mul_mode,
    input wire logic diff_en,
    input wire logic err_clr,
    iqe_if.rcv line,
    output logic [IQE_CNT_W-1:0] count,
    output logic dir_up,
    output logic ref_seen,
    output logic line_fault,
    output logic step_err
);
    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] f1;
        logic [2:0] f2;
        logic [1:0] prev;
        logic [IQE_CNT_W-1:0] cnt;
        logic up;
        logic refd;
        logic fault;
        logic err;
    } iqe_rcv_t;

    iqe_rcv_t s_q, s_d;
    logic [1:0] cur;
    logic fwd, bwd, take;

    function automatic logic [1:0] iqe_gray_inv(input logic [1:0] g);
        logic [1:0] p;
        p = {g[1], g[1] ^ g[0]};
        return p;
    endfunction

    always_comb begin
        s_d = s_q;
        // Two-stage sync of true and complement lines
        s_d.s1 = {line.a, line.b, line.z};
        s_d.s2 = s_q.s1;
        s_d.f1 = {line.a_n, line.b_n, line.z_n};
        s_d.f2 = s_q.f1;
        cur = s_q.s2[2:1];
        s_d.prev = cur;
        fwd = (cur == iqe_gray(iqe_gray_inv(s_q.prev) + 2'h1));
        bwd = (cur == iqe_gray(iqe_gray_inv(s_q.prev) - 2'h1));
        case (mul_mode)
            IQE_MUL_X1: take = (fwd && cur == 2'b10) || (bwd && cur == 2'b00);
            IQE_MUL_X2: take = (cur[1] != s_q.prev[1]);
            IQE_MUL_X4: take = 1'b1;
            default: take = 1'b1;
        endcase
        if (fwd && take) begin
            s_d.cnt = s_q.cnt + 32'h0000_0001;
            s_d.up = 1'b1;
        end else if (bwd && take) begin
            s_d.cnt = s_q.cnt - 32'h0000_0001;
            s_d.up = 1'b0;
        end
        if (s_q.s2[0]) begin
            s_d.refd = 1'b1;
        end
        if (err_clr) begin
            s_d.err = 1'b0;
            s_d.fault = 1'b0;
        end
        // Set wins over clear
        if ((cur ^ s_q.prev) == 2'b11) begin
            s_d.err = 1'b1;
        end
        if (diff_en && ((s_q.s2 ^ s_q.f2) != 3'b111)) begin
            s_d.fault = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            // Idle complements are high, so no false fault after reset
            s_q.f1 <= IQE_CMP_RST;
            s_q.f2 <= IQE_CMP_RST;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign count = s_q.cnt;
    assign dir_up = s_q.up;
    assign ref_seen = s_q.refd;
    assign line_fault = s_q.fault;
    assign step_err = s_q.err;
endmodule
`default_nettype wire

//--- shared/iqe_pkg.sv
// Shared constants and types for the quadrature encoder link
`default_nettype none
package iqe_pkg;
    // ------------------------------------------------------------
    // Channel and count multiplier configuration
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        IQE_CH_ONE = 2'b00,
        IQE_CH_TWO = 2'b01,
        IQE_CH_THREE = 2'b10
    } iqe_chan_t;

    typedef enum logic [1:0] {
        IQE_MUL_X1 = 2'b00,
        IQE_MUL_X2 = 2'b01,
        IQE_MUL_X4 = 2'b10
    } iqe_mul_t;

    // ------------------------------------------------------------
    // Sizes and reset values
    // ------------------------------------------------------------
    localparam int IQE_PPR_W = 16;
    localparam int IQE_DIV_W = 16;
    localparam int IQE_CNT_W = 32;
    localparam logic [IQE_CNT_W-1:0] IQE_CNT_RST = 32'h0000_0000;
    localparam logic [1:0] IQE_PHASE_RST = 2'h0;
    localparam logic [IQE_PPR_W-1:0] IQE_POS_RST = 16'h0000;
    localparam logic [IQE_DIV_W-1:0] IQE_DIV_RST = 16'h0000;
    // Complement sync stages start at the idle level of the inverted lines
    localparam logic [2:0] IQE_CMP_RST = 3'h7;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int IQE_CLK_HZ = 40_000_000;
    localparam int IQE_SEC_PER_MIN = 60;
    localparam int IQE_FMAX_HZ = 800_000;
    // Least clocks per quarter step at the highest pulse rate (4 steps per pulse)
    localparam int IQE_MIN_STEP_CYC = IQE_CLK_HZ / (4 * IQE_FMAX_HZ);

    // Gray sequence of {a,b} for forward rotation, indexed by phase
    function automatic logic [1:0] iqe_gray(input logic [1:0] phase);
        logic [1:0] g;
        g = {phase[1], phase[1] ^ phase[0]};
        return g;
    endfunction

    // Required pulse rate from rpm and ppr
    function automatic logic [31:0] iqe_pulse_hz(input logic [15:0] rpm,
                                                 input logic [15:0] ppr);
        logic [31:0] p;
        p = ({16'h0000, rpm} * {16'h0000, ppr}) / 32'(IQE_SEC_PER_MIN);
        return p;
    endfunction
endpackage
`default_nettype wire

//--- shared/iqe_if.sv
// Encoder line bundle with true and complement channels
`default_nettype none
interface iqe_if;
    logic a;
    logic a_n;
    logic b;
    logic b_n;
    logic z;
    logic z_n;

    modport enc (output a, output a_n, output b, output b_n, output z, output z_n);
    modport rcv (input a, input a_n, input b, input b_n, input z, input z_n);
endinterface
`default_nettype wire

//--- hdl/iqe_encoder.sv
// Encoder end: steps a shaft phase and drives quadrature lines
`default_nettype none
module iqe_encoder
    import iqe_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire iqe_chan_t chan_mode,
    input wire logic [IQE_PPR_W-1:0] ppr,
    input wire logic [IQE_DIV_W-1:0] step_div,
    input wire logic run,
    input wire logic dir_ccw,
    output logic [IQE_PPR_W-1:0] position,
    iqe_if.enc line
);
    typedef struct packed {
        logic [IQE_DIV_W-1:0] div;
        logic [1:0] phase;
        logic [IQE_PPR_W-1:0] pos;
        logic a;
        logic b;
        logic z;
    } iqe_enc_t;

    iqe_enc_t s_q, s_d;
    logic [1:0] ab;
    logic last_pos;

    always_comb begin
        s_d = s_q;
        ab = 2'h0;
        last_pos = (s_q.pos == ppr - 16'h0001);
        if (run) begin
            if (s_q.div >= step_div) begin
                s_d.div = IQE_DIV_RST;
                if (dir_ccw) begin
                    s_d.phase = s_q.phase - 2'h1;
                    if (s_q.phase == 2'h0) begin
                        s_d.pos = (s_q.pos == IQE_POS_RST) ? ppr - 16'h0001
                                                           : s_q.pos - 16'h0001;
                    end
                end else begin
                    s_d.phase = s_q.phase + 2'h1;
                    if (s_q.phase == 2'h3) begin
                        s_d.pos = last_pos ? IQE_POS_RST : s_q.pos + 16'h0001;
                    end
                end
            end else begin
                s_d.div = s_q.div + 16'h0001;
            end
        end
        ab = iqe_gray(s_d.phase);
        s_d.a = ab[1];
        s_d.b = (chan_mode == IQE_CH_ONE) ? 1'b0 : ab[0];
        s_d.z = (chan_mode == IQE_CH_THREE) && (s_d.pos == IQE_POS_RST)
                && ab[1] && ab[0];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // --------------------------------------------------------------
    // Line drive with complements
    // --------------------------------------------------------------
    assign line.a = s_q.a;
    assign line.a_n = ~s_q.a;
    assign line.b = s_q.b;
    assign line.b_n = ~s_q.b;
    assign line.z = s_q.z;
    assign line.z_n = ~s_q.z;
    assign position = s_q.pos;
endmodule
`default_nettype wire

//--- bench/iqe_monitor.sv
// Line checker for the quadrature encoder link
`default_nettype none
module iqe_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic a,
    input wire logic a_n,
    input wire logic b,
    input wire logic b_n,
    input wire logic z,
    input wire logic z_n
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_a_compl: assert property (a_n == !a) else $error("a complement");
    a_b_compl: assert property (b_n == !b) else $error("b complement");
    a_z_compl: assert property (z_n == !z) else $error("z complement");
    a_gray_step: assert property (!($changed(a) && $changed(b))) else $error("double");
    a_step_gap: assert property ($changed({a, b}) |=> $stable({a, b})) else $error("gap");
    a_zero_and: assert property (z |-> a && b) else $error("zero and");
    a_zero_rise: assert property ($rose(z) |-> $rose(a) || $rose(b)) else $error("rise");
    a_zero_width: assert property (z |=> z || $changed({a, b})) else $error("width");
    cover property ($rose(z));
    cover property ($rose(a) && b);
    cover property ($rose(b) && a);
endmodule
`default_nettype wire

//--- bench/incremental_quadrature_encoder_link_tb.sv
// Bench joining encoder and receiver ends
`default_nettype none
module incremental_quadrature_encoder_link_tb import iqe_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst = 1, run = 0, dir_ccw = 0, ce = 1;
    iqe_chan_t chan_mode = IQE_CH_THREE;
    iqe_mul_t mul_mode = IQE_MUL_X4;
    logic [15:0] position;
    logic [31:0] count;
    logic dir_up, ref_seen, line_fault, step_err;
    logic signed [31:0] e4, e2, e1;
    logic [1:0] prev;
    int n_errors = 0, checked = 0;
    iqe_if line();
    iqe_encoder iqe_encoder_i (.clk(clk), .rst(rst), .ce(ce), .chan_mode(chan_mode),
        .ppr(16'h0002), .step_div(16'h0001), .run(run), .dir_ccw(dir_ccw),
        .position(position), .line(line.enc));
    iqe_receiver iqe_receiver_i (.clk(clk), .rst(rst), .ce(ce), .mul_mode(mul_mode),
        .diff_en(1'b1), .err_clr(1'b0), .line(line.rcv), .count(count), .dir_up(dir_up),
        .ref_seen(ref_seen), .line_fault(line_fault), .step_err(step_err));
    iqe_monitor iqe_monitor_i (.clk(clk), .rst(rst), .a(line.a), .a_n(line.a_n),
        .b(line.b), .b_n(line.b_n), .z(line.z), .z_n(line.z_n));
    always #12.5 clk = ~clk;
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s exp %0h seen %0h", name, exp, seen);
        end
    endtask
    // --------------------------------------------
    // Wire watcher: expected counts from line steps
    // --------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            {e4, e2, e1} <= '0;
            prev <= 2'h0;
        end else if ({line.a, line.b} !== prev) begin
            if (chan_mode == IQE_CH_ONE) begin
                check("b_idle", 32'(line.b), 32'h0);
            end else begin
                check("order", 32'({line.a, line.b}),
                    32'(dir_ccw ? {~prev[0], prev[1]} : {prev[0], ~prev[1]}));
            end
            e4 <= e4 + (dir_ccw ? -1 : 1);
            e2 <= e2 + ((line.a != prev[1]) ? (dir_ccw ? -1 : 1) : 0);
            e1 <= e1 + ((!dir_ccw && {line.a, line.b} == 2'h2) ? 1 :
                        (dir_ccw && {line.a, line.b} == 2'h0) ? -1 : 0);
            prev <= {line.a, line.b};
        end
    end
    task do_reset(input iqe_chan_t ch, input iqe_mul_t mm);
        @(posedge clk);
        rst <= 1;
        chan_mode <= ch;
        mul_mode <= mm;
        repeat (6) @(posedge clk);
        rst <= 0;
    endtask
    task spin(input logic ccw, input int n);
        @(posedge clk);
        dir_ccw <= ccw;
        run <= 1;
        repeat (n) @(posedge clk);
        run <= 0;
        repeat (8) @(posedge clk);
    endtask
    function automatic logic [31:0] expect_cnt();
        return mul_mode == IQE_MUL_X4 ? e4 : mul_mode == IQE_MUL_X2 ? e2 : e1;
    endfunction
    task summarize;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        for (int m = 0; m < 3; m++) begin
            do_reset(IQE_CH_THREE, iqe_mul_t'(m));
            spin(0, 40);
            check("rate", 32'(e4 >= 19 && e4 <= 21), 32'h1);
            check("count_fwd", count, expect_cnt());
            check("dir_fwd", 32'(dir_up), 32'h1);
            check("pos", 32'(position), 32'((e4 / 4) % 2));
            check("ref", 32'(ref_seen), 32'h1);
            // Enable low: stepping requested but nothing may move
            ce <= 0;
            spin(0, 12);
            check("frozen_cnt", count, 32'(5 << m));
            check("frozen_pos", 32'(position), 32'h1);
            ce <= 1;
            spin(1, 26);
            check("count_back", count, expect_cnt());
            check("dir_back", 32'(dir_up), 32'h0);
            check("faults", 32'({line_fault, step_err}), 32'h0);
        end
        do_reset(IQE_CH_ONE, IQE_MUL_X1);
        spin(0, 20);
        check("ref_one", 32'(ref_seen), 32'h0);
        summarize;
    end
endmodule
`default_nettype wire
